// [ebcp_defines.svh]
// Field layout and timing constants of the bus cycle phaser
`ifndef EBCP_DEFINES_SVH
`define EBCP_DEFINES_SVH

// Timing configuration word of one chip select
`define EBCP_CFG_W          16
`define EBCP_AB_BASE_BIT    0
`define EBCP_AB_EXT_LSB     1
`define EBCP_AB_EXT_MSB     2
`define EBCP_C_LSB          3
`define EBCP_C_MSB          4
`define EBCP_D_BIT          5
`define EBCP_E_LSB          6
`define EBCP_E_MSB          10
`define EBCP_F_LSB          11
`define EBCP_F_MSB          12
`define EBCP_RDY_EN_BIT     13
`define EBCP_RDY_POL_BIT    14
`define EBCP_RDY_ASYNC_BIT  15

// Phase length arithmetic
`define EBCP_LEN_W          6
`define EBCP_LEN_ONE        6'h01
`define EBCP_LEN_ZERO       6'h00
`define EBCP_RUN_W          8
`define EBCP_RUN_MAX        8'hFF
`define EBCP_RUN_ZERO       8'h00
`define EBCP_RUN_ONE        8'h01

`endif

// [ebcp_mem_model.sv]
// Behavioural external memory with ready handshake on the parallel bus
`timescale 1ns/1ps
module ebcp_mem_model (
    // Bus clock and pins from the phaser
    input  wire logic        bus_clk,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [23:0] addr_out,
    input  wire logic [15:0] data_out,
    // Ready behaviour chosen by the bench
    input  wire logic        rdy_pol,
    input  wire logic [3:0]  rdy_wait,
    // Pins back to the phaser
    output logic [15:0]      data_in,
    output logic             ready_in
);
    logic [15:0] mem [0:15];
    logic [3:0]  cnt;
    initial begin
        data_in  = 16'h0000;
        ready_in = 1'b0;
        cnt      = 4'h0;
    end
    // Store writes, answer reads, scramble released data lines
    always @(posedge bus_clk) begin
        if (!wr_n) mem[addr_out[3:0]] <= data_out;
        data_in <= !rd_n ? mem[addr_out[3:0]] : ~data_in;
    end
    // Ready goes active rdy_wait units into a command, drops after it
    always @(posedge bus_clk) begin
        cnt      <= (rd_n && wr_n) ? 4'h0 : cnt + {3'h0, cnt != 4'hF};
        ready_in <= ~((!(rd_n && wr_n) && cnt >= rdy_wait) ^ rdy_pol);
    end
endmodule : ebcp_mem_model

// [ebcp_phaser.sv]
// External bus cycle phaser: five programmable phases per bus cycle
// What this block does
// RULE1: Every bus cycle runs address setup, command delay, write setup, access, hold in order.
// RULE2: Each phase length comes from the chip select timing word; command delay is 0 to 3 units.
// RULE3: Address setup lasts 1 or 2 units plus 0 to 3 more when the chip select changes.
// RULE4: The write setup or tristate phase lasts 0 or 1 unit.
// RULE5: The access phase lasts 1 to 32 units before any ready extension.
// RULE6: The hold phase lasts 0 to 3 units.
// RULE7: With handshake enabled the access phase is held until the partner signals ready.
// RULE8: The bus reference clock is the system clock driven out, one period per period.
// RULE9: The active level of the ready input is chosen per chip select.
// RULE10: Asynchronous ready passes one extra synchroniser stage, adding a wait state.
// RULE11: Ready sampled inactive inserts a wait state; sampled active ends the cycle.
// RULE12: One phase unit is one bus reference clock period; counters run on that clock.
// RULE13: After hold the sequencer goes idle or starts the next pending cycle.
`timescale 1ns/1ps
`include "ebcp_defines.svh"
module ebcp_phaser import ebcp_pkg::*; #(
    parameter int NUM_CS = 4,
    parameter int CS_W   = 2,
    parameter int ADDR_W = 24,
    parameter int DATA_W = 16
) (
    // Core clock domain
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    // Link clock: system clock driving the bus
    input  wire logic                   bus_clk,
    // Cycle request
    input  wire logic                   req_valid,
    input  wire logic                   req_write,
    input  wire logic [CS_W-1:0]        req_cs,
    input  wire logic [ADDR_W-1:0]      req_addr,
    input  wire logic [DATA_W-1:0]      req_wdata,
    output logic                        req_ready,
    // Cycle answer
    output logic                        done,
    output logic [DATA_W-1:0]           rd_data,
    // Timing configuration per chip select and reference clock enable
    input  wire logic [NUM_CS-1:0][`EBCP_CFG_W-1:0] chip_select_timing_config,
    input  wire logic                   bus_reference_clock_enable,
    // External bus pins
    output logic                        bus_reference_clock,
    output logic [NUM_CS-1:0]           cs_n,
    output logic                        ale,
    output logic                        rd_n,
    output logic                        wr_n,
    output logic [ADDR_W-1:0]           addr_out,
    output logic [DATA_W-1:0]           data_out,
    output logic                        data_oe_n,
    input  wire logic [DATA_W-1:0]      data_in,
    input  wire logic                   ready_in
);
    ////////////////////////////////////////////////////////////////////////
    // Core domain: request capture and completion
    logic                   busy_q, busy_d;
    logic                   req_tgl_q, req_tgl_d;
    logic                   ack_seen_q, ack_seen_d;
    logic                   ack_s;
    logic                   done_q, done_d;
    logic                   rdy_out_q, rdy_out_d;
    logic                   h_write_q, h_write_d;
    logic [CS_W-1:0]        h_cs_q, h_cs_d;
    logic [ADDR_W-1:0]      h_addr_q, h_addr_d;
    logic [DATA_W-1:0]      h_wdata_q, h_wdata_d;
    logic [`EBCP_CFG_W-1:0] h_cfg_q, h_cfg_d;
    logic [DATA_W-1:0]      rdq_q, rdq_d;
    logic                   done_tgl_q, done_tgl_d;
    logic [DATA_W-1:0]      rdat_q, rdat_d;

    ebcp_sync #(.W(1)) u_ack_sync (
        .clk (core_clk),
        .rst (rst),
        .d   (done_tgl_q),
        .q   (ack_s)
    );

    // Accept one request, hold it until the bus side answers
    always_comb begin
        busy_d     = busy_q;
        req_tgl_d  = req_tgl_q;
        ack_seen_d = ack_s;
        done_d     = 1'b0;
        rdq_d      = rdq_q;
        h_write_d  = h_write_q;
        h_cs_d     = h_cs_q;
        h_addr_d   = h_addr_q;
        h_wdata_d  = h_wdata_q;
        h_cfg_d    = h_cfg_q;
        if (ack_s != ack_seen_q) begin
            busy_d = 1'b0;
            done_d = 1'b1;
            rdq_d  = rdat_q;    // Stable until the next cycle completes
        end else if (req_valid && !busy_q) begin
            busy_d    = 1'b1;
            req_tgl_d = ~req_tgl_q;
            h_write_d = req_write;
            h_cs_d    = req_cs;
            h_addr_d  = req_addr;
            h_wdata_d = req_wdata;
            h_cfg_d   = chip_select_timing_config[req_cs];
        end
        rdy_out_d = !busy_d;
    end

    // Core domain registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            busy_q     <= 1'b0;
            req_tgl_q  <= 1'b0;
            ack_seen_q <= 1'b0;
            done_q     <= 1'b0;
            rdy_out_q  <= 1'b0;
            rdq_q      <= '0;
            h_write_q  <= 1'b0;
            h_cs_q     <= '0;
            h_addr_q   <= '0;
            h_wdata_q  <= '0;
            h_cfg_q    <= '0;
        end else begin
            busy_q     <= busy_d;
            req_tgl_q  <= req_tgl_d;
            ack_seen_q <= ack_seen_d;
            done_q     <= done_d;
            rdy_out_q  <= rdy_out_d;
            rdq_q      <= rdq_d;
            h_write_q  <= h_write_d;
            h_cs_q     <= h_cs_d;
            h_addr_q   <= h_addr_d;
            h_wdata_q  <= h_wdata_d;
            h_cfg_q    <= h_cfg_d;
        end
    end

    assign req_ready = rdy_out_q;
    assign done      = done_q;
    assign rd_data   = rdq_q;

    ////////////////////////////////////////////////////////////////////////
    // Bus domain: synchronisers and reference clock
    logic              req_s, rdy_s, clken_s;
    logic [DATA_W-1:0] din_s;
    logic              rdy3_q;
    logic              clken_n_q;

    ebcp_sync #(.W(1)) u_req_sync (
        .clk (bus_clk), .rst (rst), .d (req_tgl_q), .q (req_s)
    );
    ebcp_sync #(.W(1)) u_rdy_sync (
        .clk (bus_clk), .rst (rst), .d (ready_in), .q (rdy_s)
    );
    ebcp_sync #(.W(1)) u_cke_sync (
        .clk (bus_clk), .rst (rst), .d (bus_reference_clock_enable), .q (clken_s)
    );
    ebcp_sync #(.W(DATA_W)) u_din_sync (
        .clk (bus_clk), .rst (rst), .d (data_in), .q (din_s)
    );

    // Enable changes on the falling edge so the gated clock never glitches
    always_ff @(negedge bus_clk or posedge rst) begin
        if (rst) clken_n_q <= 1'b0;
        else     clken_n_q <= clken_s;
    end
    assign bus_reference_clock = bus_clk & clken_n_q;  // RULE8

    ////////////////////////////////////////////////////////////////////////
    // Bus domain: phase sequencer
    ebcp_phase_t            ph_q, ph_d;
    logic [`EBCP_LEN_W-1:0] cnt_q, cnt_d;
    logic [`EBCP_CFG_W-1:0] cfg_q, cfg_d;
    logic                   wr_q, wr_d;
    logic [CS_W-1:0]        cs_q, cs_d, last_cs_q, last_cs_d;
    logic [ADDR_W-1:0]      addr_q, addr_d;
    logic [DATA_W-1:0]      wdat_q, wdat_d;
    logic                   req_seen_q, req_seen_d;
    logic                   rdy3_d;
    logic [`EBCP_LEN_W-1:0] c_len, d_len, e_len, f_len, ab_new;
    logic                   pend, leave, rdy_act, rdy_ok;
    ebcp_phase_t            st_ph, fin_ph, ad_ph, ac_ph, aab_ph, ae_ph;
    logic [`EBCP_LEN_W-1:0] st_cnt, fin_cnt, ad_cnt, ac_cnt;
    logic [`EBCP_LEN_W-1:0] aab_cnt, ae_cnt;

    // Phase lengths of the running cycle
    always_comb begin
        c_len = {4'h0, cfg_q[`EBCP_C_MSB:`EBCP_C_LSB]};  // RULE2
        d_len = {5'h00, cfg_q[`EBCP_D_BIT]};  // RULE4
        e_len = {1'b0, cfg_q[`EBCP_E_MSB:`EBCP_E_LSB]}
                + `EBCP_LEN_ONE;  // RULE5
        f_len = {4'h0, cfg_q[`EBCP_F_MSB:`EBCP_F_LSB]};  // RULE6
        // Address setup of a new cycle, stretched on window change
        ab_new = `EBCP_LEN_ONE + {5'h00, h_cfg_q[`EBCP_AB_BASE_BIT]}
                 + ((h_cs_q != last_cs_q)
                    ? {4'h0, h_cfg_q[`EBCP_AB_EXT_MSB:`EBCP_AB_EXT_LSB]}
                    : `EBCP_LEN_ZERO);  // RULE3
    end

    // Ready level, polarity and extra stage
    always_comb begin
        rdy3_d  = rdy_s;
        rdy_act = cfg_q[`EBCP_RDY_ASYNC_BIT] ? rdy3_q : rdy_s;  // RULE10
        if (!cfg_q[`EBCP_RDY_POL_BIT])
            rdy_act = ~rdy_act;  // RULE9
        rdy_ok  = !cfg_q[`EBCP_RDY_EN_BIT] || rdy_act;  // RULE7 RULE11
    end

    // Successor of each phase, skipping zero-length ones
    always_comb begin
        pend    = req_s != req_seen_q;
        leave   = cnt_q == `EBCP_LEN_ZERO;  // RULE12
        st_ph   = EBCP_AB;
        st_cnt  = ab_new - `EBCP_LEN_ONE;
        fin_ph  = pend ? st_ph : EBCP_IDLE;  // RULE13
        fin_cnt = pend ? st_cnt : `EBCP_LEN_ZERO;
        ad_ph   = EBCP_E;
        ad_cnt  = e_len - `EBCP_LEN_ONE;
        ac_ph   = (d_len != `EBCP_LEN_ZERO) ? EBCP_D : ad_ph;
        ac_cnt  = (d_len != `EBCP_LEN_ZERO) ? `EBCP_LEN_ZERO : ad_cnt;
        aab_ph  = (c_len != `EBCP_LEN_ZERO) ? EBCP_C : ac_ph;
        aab_cnt = (c_len != `EBCP_LEN_ZERO) ? c_len - `EBCP_LEN_ONE
                                            : ac_cnt;
        ae_ph   = (f_len != `EBCP_LEN_ZERO) ? EBCP_F : fin_ph;
        ae_cnt  = (f_len != `EBCP_LEN_ZERO) ? f_len - `EBCP_LEN_ONE
                                            : fin_cnt;
    end

    // Phase state, counter and cycle data
    always_comb begin
        ph_d       = ph_q;
        cnt_d      = leave ? cnt_q : cnt_q - `EBCP_LEN_ONE;
        cfg_d      = cfg_q;
        wr_d       = wr_q;
        cs_d       = cs_q;
        last_cs_d  = last_cs_q;
        addr_d     = addr_q;
        wdat_d     = wdat_q;
        req_seen_d = req_seen_q;
        done_tgl_d = done_tgl_q;
        rdat_d     = rdat_q;
        case (ph_q)
            EBCP_IDLE: begin
                if (pend) begin
                    ph_d  = st_ph;
                    cnt_d = st_cnt;
                end
            end
            EBCP_AB: begin
                if (leave) begin
                    ph_d  = aab_ph;  // RULE1
                    cnt_d = aab_cnt;
                end
            end
            EBCP_C: begin
                if (leave) begin
                    ph_d  = ac_ph;  // RULE1
                    cnt_d = ac_cnt;
                end
            end
            EBCP_D: begin
                if (leave) begin
                    ph_d  = ad_ph;  // RULE1
                    cnt_d = ad_cnt;
                end
            end
            EBCP_E: begin
                // Wait state while ready is not active
                if (leave && rdy_ok) begin  // RULE7 RULE11
                    ph_d       = ae_ph;  // RULE1
                    cnt_d      = ae_cnt;
                    rdat_d     = din_s;
                    done_tgl_d = ~done_tgl_q;
                end
            end
            EBCP_F: begin
                if (leave) begin
                    ph_d  = fin_ph;  // RULE13
                    cnt_d = fin_cnt;
                end
            end
            default: begin
                ph_d  = EBCP_IDLE;
                cnt_d = `EBCP_LEN_ZERO;
            end
        endcase
        // Take the held request when a new cycle starts
        if (ph_d == EBCP_AB && ph_q != EBCP_AB) begin
            cfg_d      = h_cfg_q;
            wr_d       = h_write_q;
            cs_d       = h_cs_q;
            last_cs_d  = h_cs_q;
            addr_d     = h_addr_q;
            wdat_d     = h_wdata_q;
            req_seen_d = req_s;
        end
    end

    // Pin levels follow the next phase
    logic [NUM_CS-1:0] cs_n_q, cs_n_d;
    logic              ale_q, ale_d, rd_n_q, rd_n_d, wr_n_q, wr_n_d;
    logic              oe_n_q, oe_n_d;
    always_comb begin
        cs_n_d = '1;
        if (ph_d != EBCP_IDLE)
            cs_n_d[cs_d] = 1'b0;
        ale_d  = ph_d == EBCP_AB;
        rd_n_d = !(ph_d == EBCP_E && !wr_d);
        wr_n_d = !(ph_d == EBCP_E && wr_d);
        oe_n_d = !(wr_d && (ph_d == EBCP_D || ph_d == EBCP_E
                            || ph_d == EBCP_F));
    end

    // Bus domain registers
    always_ff @(posedge bus_clk or posedge rst) begin
        if (rst) begin
            ph_q       <= EBCP_IDLE;
            cnt_q      <= `EBCP_LEN_ZERO;
            cfg_q      <= '0;
            wr_q       <= 1'b0;
            cs_q       <= '0;
            last_cs_q  <= '0;
            addr_q     <= '0;
            wdat_q     <= '0;
            req_seen_q <= 1'b0;
            done_tgl_q <= 1'b0;
            rdat_q     <= '0;
            rdy3_q     <= 1'b0;
            cs_n_q     <= '1;
            ale_q      <= 1'b0;
            rd_n_q     <= 1'b1;
            wr_n_q     <= 1'b1;
            oe_n_q     <= 1'b1;
        end else begin
            ph_q       <= ph_d;
            cnt_q      <= cnt_d;
            cfg_q      <= cfg_d;
            wr_q       <= wr_d;
            cs_q       <= cs_d;
            last_cs_q  <= last_cs_d;
            addr_q     <= addr_d;
            wdat_q     <= wdat_d;
            req_seen_q <= req_seen_d;
            done_tgl_q <= done_tgl_d;
            rdat_q     <= rdat_d;
            rdy3_q     <= rdy3_d;
            cs_n_q     <= cs_n_d;
            ale_q      <= ale_d;
            rd_n_q     <= rd_n_d;
            wr_n_q     <= wr_n_d;
            oe_n_q     <= oe_n_d;
        end
    end

    assign cs_n      = cs_n_q;
    assign ale       = ale_q;
    assign rd_n      = rd_n_q;
    assign wr_n      = wr_n_q;
    assign addr_out  = addr_q;
    assign data_out  = wdat_q;
    assign data_oe_n = oe_n_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks: cycles spent in the current phase
    logic [`EBCP_RUN_W-1:0] run_q, run_d;
    logic [`EBCP_LEN_W-1:0] ab_exp_q, ab_exp_d;
    always_comb begin
        run_d = (ph_d != ph_q) ? `EBCP_RUN_ZERO
              : (run_q == `EBCP_RUN_MAX) ? run_q : run_q + `EBCP_RUN_ONE;
    end
    // Expected address setup, judged against the previous cycle's select
    always_comb begin
        ab_exp_d = ab_exp_q;
        if (ph_d == EBCP_AB && ph_q != EBCP_AB)
            ab_exp_d = `EBCP_LEN_ONE + {5'h00, h_cfg_q[`EBCP_AB_BASE_BIT]}
                     + ((h_cs_q == cs_q) ? `EBCP_LEN_ZERO
                     : {4'h0, h_cfg_q[`EBCP_AB_EXT_MSB:`EBCP_AB_EXT_LSB]});
    end
    always_ff @(posedge bus_clk or posedge rst) begin
        if (rst) begin
            run_q    <= `EBCP_RUN_ZERO;
            ab_exp_q <= `EBCP_LEN_ZERO;
        end else begin
            run_q    <= run_d;
            ab_exp_q <= ab_exp_d;
        end
    end

    phase_order_a: assert property (@(posedge bus_clk) disable iff (rst)  // RULE1
        ph_q == EBCP_AB |=> ph_q inside {EBCP_AB, EBCP_C, EBCP_D, EBCP_E})
        else $error("address setup left to a wrong phase");
    cmd_delay_a: assert property (@(posedge bus_clk) disable iff (rst)  // RULE2
        ph_q == EBCP_C && ph_d != EBCP_C
        |-> {2'b00, run_q[5:0]} + 8'h01 == {2'b00, c_len})
        else $error("command delay length wrong");
    addr_setup_a: assert property (@(posedge bus_clk) disable iff (rst)  // RULE3
        ph_q == EBCP_AB && ph_d != EBCP_AB
        |-> run_q[5:0] + 6'h01 == ab_exp_q)
        else $error("address setup length wrong");
    write_setup_a: assert property (@(posedge bus_clk) disable iff (rst)  // RULE4
        $rose(ph_q == EBCP_D) |=> ph_q != EBCP_D)
        else $error("write setup longer than one unit");
    access_len_a: assert property (@(posedge bus_clk) disable iff (rst)  // RULE5
        ph_q == EBCP_E && ph_d != EBCP_E
        |-> run_q[5:0] + 6'h01 >= e_len
            && (cfg_q[`EBCP_RDY_EN_BIT] || run_q[5:0] + 6'h01 == e_len))
        else $error("access phase length wrong");
    hold_len_a: assert property (@(posedge bus_clk) disable iff (rst)  // RULE6
        ph_q == EBCP_F && ph_d != EBCP_F
        |-> run_q[5:0] + 6'h01 == f_len)
        else $error("hold phase length wrong");
    ready_wait_a: assert property (@(posedge bus_clk) disable iff (rst)  // RULE11
        ph_q == EBCP_E && leave && cfg_q[`EBCP_RDY_EN_BIT] && !rdy_act
        |=> ph_q == EBCP_E && !rd_n_q | !wr_n_q)
        else $error("access ended without ready");
    async_stage_a: assert property (@(posedge bus_clk) disable iff (rst)  // RULE10
        ph_q == EBCP_E && cfg_q[`EBCP_RDY_ASYNC_BIT]
        |-> rdy_act == (cfg_q[`EBCP_RDY_POL_BIT] ~^ $past(ready_in, 3)))
        else $error("async ready skipped its extra stage");
    cycle_end_a: assert property (@(posedge bus_clk) disable iff (rst)  // RULE13
        ph_q == EBCP_F && leave |=> ph_q inside {EBCP_IDLE, EBCP_AB})
        else $error("hold not followed by idle or new cycle");
    strobe_phase_a: assert property (@(posedge bus_clk) disable iff (rst)  // RULE7
        !rd_n_q || !wr_n_q |-> ph_q == EBCP_E)
        else $error("command strobe outside access phase");

    write_cycle_c: cover property (@(posedge bus_clk) disable iff (rst)
        ph_q == EBCP_F && wr_q);
    read_cycle_c: cover property (@(posedge bus_clk) disable iff (rst)
        ph_q == EBCP_E && !wr_q ##1 ph_q != EBCP_E);
    ready_wait_c: cover property (@(posedge bus_clk) disable iff (rst)
        ph_q == EBCP_E && leave && !rdy_ok);
    back_to_back_c: cover property (@(posedge bus_clk) disable iff (rst)
        ph_q == EBCP_F ##1 ph_q == EBCP_AB);
endmodule : ebcp_phaser

// [ebcp_pkg.sv]
// Types shared by the bus cycle phaser
package ebcp_pkg;
    // One-hot bus cycle phases
    typedef enum logic [5:0] {
        EBCP_IDLE = 6'h01,
        EBCP_AB   = 6'h02,
        EBCP_C    = 6'h04,
        EBCP_D    = 6'h08,
        EBCP_E    = 6'h10,
        EBCP_F    = 6'h20
    } ebcp_phase_t;
endpackage : ebcp_pkg

// [ebcp_sync.sv]
// Two flip-flop synchroniser for levels entering a clock domain
`timescale 1ns/1ps
module ebcp_sync #(
    parameter int W = 1
) (
    // Clock and reset of the receiving domain
    input  wire logic         clk,
    input  wire logic         rst,
    // Level in and synchronised level out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    // Next values of both stages
    always_comb begin
        meta_d = d;
        sync_d = meta_q;
    end

    // First stage read only by the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign q = sync_q;
endmodule : ebcp_sync

// [test_ebcp_phaser.sv]
// Self-checking bench for the external bus cycle phaser
`timescale 1ns/1ps
module test_ebcp_phaser;
    logic             core_clk, rst, bus_clk, req_valid, req_write;
    logic [1:0]       req_cs;
    logic [23:0]      req_addr, addr_out;
    logic [15:0]      req_wdata, rd_data, data_out, data_in, got;
    logic [3:0][15:0] cfg;
    logic [3:0]       cs_n, rdy_wait;
    logic             req_ready, done, bus_reference_clock_enable, bus_reference_clock;
    logic             ale, rd_n, wr_n, data_oe_n, ready_in, rdy_pol;
    int               fails, checked, n_ale, n_cmd, n_cs, n_oe, n_ref, cyc;

    ebcp_phaser i_dut (.core_clk(core_clk), .rst(rst), .bus_clk(bus_clk),
        .req_valid(req_valid), .req_write(req_write), .req_cs(req_cs),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
        .done(done), .rd_data(rd_data), .chip_select_timing_config(cfg),
        .bus_reference_clock_enable(bus_reference_clock_enable), .cs_n(cs_n), .ale(ale),
        .bus_reference_clock(bus_reference_clock), .rd_n(rd_n),
        .wr_n(wr_n), .addr_out(addr_out), .data_out(data_out),
        .data_oe_n(data_oe_n), .data_in(data_in), .ready_in(ready_in));
    ebcp_mem_model i_mem (.bus_clk(bus_clk), .rd_n(rd_n), .wr_n(wr_n),
        .addr_out(addr_out), .data_out(data_out), .rdy_pol(rdy_pol),
        .rdy_wait(rdy_wait), .data_in(data_in), .ready_in(ready_in));

    ////////////////////////////////////////////////////////////////////////
    // Clocks, bus pin counters and hang guard
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        bus_clk = 1'b0;
        #3;
        forever #6 bus_clk = ~bus_clk;
    end
    always @(posedge bus_clk) begin
        n_ale += ale;
        n_cmd += !(rd_n && wr_n);
        n_cs  += (cs_n != 4'hF);
        n_oe  += !data_oe_n;
    end
    always @(posedge bus_reference_clock) n_ref++;
    always @(posedge core_clk) begin
        if (++cyc == 20000) begin
            fails++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checked %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    function automatic logic [15:0] tw(input int b, x, c, d, e, f, en, p, a);
        return {a[0], p[0], en[0], f[1:0], e[4:0], d[0], c[1:0], x[1:0], b[0]};
    endfunction : tw
    task automatic clr();
        n_ale = 0;
        n_cmd = 0;
        n_cs  = 0;
        n_oe  = 0;
    endtask : clr
    task automatic issue(input logic w, input logic [1:0] cs,
                         input logic [23:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(negedge core_clk);
        req_write = w;
        req_cs    = cs;
        req_addr  = a;
        req_wdata = d;
        req_valid = 1'b1;
        while (req_ready !== 1'b1 && n < 100) begin
            @(negedge core_clk);
            n++;
        end
        @(negedge core_clk);
        req_valid = 1'b0;
        while (done !== 1'b1 && n < 400) begin
            @(negedge core_clk);
            n++;
        end
        chk(n < 400, 1);
        got = rd_data;
    endtask : issue
    task automatic settle();
        int n;
        n = 0;
        while (cs_n !== 4'hF && n < 100) begin
            @(negedge core_clk);
            n++;
        end
        repeat (2) @(negedge core_clk);
    endtask : settle
    task automatic run(input logic w, input logic [1:0] cs,
        input logic [15:0] word, input logic [23:0] a, input logic [15:0] d);
        cfg[cs] = word;
        clr();
        issue(w, cs, a, d);
        settle();
    endtask : run

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_phases();
        int t [3][5] = '{'{0, 0, 0, 0, 0}, '{1, 3, 1, 31, 3}, '{0, 2, 1, 4, 1}};
        for (int i = 0; i < 3; i++) begin
            run(1'b1, 2'h0, tw(t[i][0], 0, t[i][1], t[i][2], t[i][3], t[i][4],
                0, 1, 0), 24'(i), 16'hA5C0 + 16'(i));
            chk(n_ale, 1 + t[i][0]);
            chk(n_cmd, 1 + t[i][3]);
            chk(n_oe, 1 + t[i][2] + t[i][3] + t[i][4]);
            chk(n_cs, 2 + t[i][0] + t[i][1] + t[i][2] + t[i][3] + t[i][4]);
        end
        $display("test phases done");
    endtask : t_phases
    task automatic t_window();
        run(1'b1, 2'h1, tw(1, 3, 0, 0, 0, 0, 0, 1, 0), 24'h10, 16'h1111);
        chk(n_ale, 5);
        run(1'b1, 2'h1, cfg[1], 24'h11, 16'h2222);
        chk(n_ale, 2);
        run(1'b0, 2'h0, tw(0, 0, 0, 0, 7, 0, 0, 1, 0), 24'h2, 16'h0000);
        chk(got, 16'hA5C2);
        $display("test window done");
    endtask : t_window
    task automatic t_b2b();
        cfg[0] = tw(0, 0, 0, 0, 7, 3, 0, 1, 0);
        clr();
        issue(1'b0, 2'h0, 24'h0, 16'h0000);
        issue(1'b0, 2'h0, 24'h1, 16'h0000);
        settle();
        chk(got, 16'h2222);
        chk(n_ale, 2);
        chk(n_cmd, 16);
        $display("test back to back done");
    endtask : t_b2b
    task automatic t_ready();
        int base;
        run(1'b1, 2'h0, tw(0, 0, 0, 0, 0, 0, 1, 1, 0), 24'h4, 16'h4444);
        base = n_cmd;
        chk(base > 1, 1);
        rdy_wait = 4'h4;
        run(1'b1, 2'h0, cfg[0], 24'h4, 16'h4444);
        chk(n_cmd, base + 4);
        rdy_wait = 4'h0;
        rdy_pol  = 1'b0;
        run(1'b1, 2'h0, tw(0, 0, 0, 0, 0, 0, 1, 0, 0), 24'h4, 16'h4444);
        chk(n_cmd, base);
        rdy_pol = 1'b1;
        run(1'b1, 2'h0, tw(0, 0, 0, 0, 0, 0, 1, 1, 1), 24'h4, 16'h4444);
        chk(n_cmd, base + 1);
        $display("test ready done");
    endtask : t_ready
    task automatic t_bus_reference_clock();
        repeat (4) @(negedge core_clk);
        n_ref = 0;
        repeat (6) @(negedge core_clk);
        chk(n_ref, 20);
        bus_reference_clock_enable = 1'b0;
        repeat (4) @(negedge core_clk);
        n_ref = 0;
        repeat (6) @(negedge core_clk);
        chk(n_ref, 0);
        $display("test clock out done");
    endtask : t_bus_reference_clock

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst           = 1'b1;
        req_valid     = 1'b0;
        req_write     = 1'b0;
        req_cs        = 2'h0;
        req_addr      = 24'h000000;
        req_wdata     = 16'h0000;
        cfg           = '0;
        bus_reference_clock_enable = 1'b1;
        rdy_pol       = 1'b1;
        rdy_wait      = 4'h0;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        repeat (2) @(negedge core_clk);
        t_phases();
        t_window();
        t_b2b();
        t_ready();
        t_bus_reference_clock();
        give_verdict();
    end
endmodule : test_ebcp_phaser
